// File: logic/ext_edge_detect.sv
/*
 holds the edge detector of the external interrupt pin.
 assumes the pin is synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module ext_edge_detect
   import irq_pkg::*;
(
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // pin and polarity
   input  wire logic ext_pin_i,
   input  wire logic ext_pin_edge_select_i,
   // detected edge
   output logic      edge_o
);

   typedef struct packed
   {
      logic prev;
      logic edge_hit;
   } edge_state_t;

   edge_state_t s_r;
   edge_state_t s_nxt;

   // ============================================================
   // edge of the selected polarity
   always_comb
   begin
      s_nxt          = s_r;
      s_nxt.prev     = ext_pin_i;
      s_nxt.edge_hit = ext_pin_edge_select_i ? (ext_pin_i & ~s_r.prev)
                                             : (~ext_pin_i & s_r.prev); // R05
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign edge_o = s_r.edge_hit;

   a_edge_polarity: assert property (@(posedge clk_i) disable iff (rst_i)
      edge_o |-> ($past(ext_pin_i, 1) == $past(ext_pin_edge_select_i, 1))
              && ($past(ext_pin_i, 2) != $past(ext_pin_edge_select_i, 1)))
      else $error("edge reported with wrong polarity"); // R05

endmodule // ext_edge_detect

`default_nettype wire

// File: logic/interrupt_wake_and_context_save.sv
/*
 holds the interrupt gating, wake from sleep, context save and restore,
 and the avalon-mm register slave of the interrupt block.
 assumes the core sequencer pulses its strobes for one cycle each and
 takes vector, push and restore pulses at the edge that ends them.
*/
`timescale 1ns/1ps
`default_nettype none
`include "irq_defs.svh"

// Overview of operation
// R01 - wake needs enable armed before sleep
// R02 - wake vectors if global enable, else continues
// R03 - one instruction after sleep before vectoring
// R04 - pin edge request gated by pin enable
// R05 - edge select one rising, zero falling
// R06 - valid pin edge sets pin flag
// R07 - flag with both enables redirects to vector
// R08 - entry pushes return address
// R09 - entry copies core registers into shadows
// R10 - return restores core registers from shadows
// R11 - shadows readable and writable by software
// R12 - two cell enables, upper bits zero
// R13 - only clockless sources can wake
// R14 - software clears flags; they stay pending

module interrupt_wake_and_context_save
   import irq_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // avalon-mm slave
   input  wire logic [7:0]  address_i,
   input  wire logic        read_i,
   input  wire logic        write_i,
   input  wire logic [3:0]  byteenable_i,
   input  wire logic [31:0] writedata_i,
   output logic      [31:0] readdata_o,
   output logic             waitrequest_o,
   output logic             irq_o,
   // external pin and peripheral sources
   input  wire logic        ext_pin_i,
   input  wire logic [1:0]  cell_flag_i,
   input  wire logic [1:0]  cell_clockless_i,
   // core sequencer strobes
   input  wire logic        instr_done_i,
   input  wire logic        sleep_enter_i,
   input  wire logic        return_i,
   input  wire logic [14:0] pc_next_i,
   input  wire logic [63:0] core_regs_i,
   // core sequencer commands
   output logic             vector_o,
   output logic             push_pc_o,
   output logic      [14:0] push_addr_o,
   output logic             restore_o,
   output logic      [63:0] restore_regs_o,
   output logic             wake_o,
   output logic             asleep_o
);

   typedef struct packed
   {
      irq_state_t   state;
      logic         global_irq_enable;
      logic         peripheral_irq_master_enable;
      logic         ext_pin_irq_enable;
      logic         ext_pin_edge_select;
      logic         ext_pin_irq_flag;
      logic [1:0]   peripheral_irq_enable_three;
      logic [2:0]   sts;
      logic [2:0]   msk;
      shadow_bank_t shadow;
      logic         arm_inte;
      logic         arm_peripheral_irq_master_enable;
      logic [1:0]   arm_cell;
      logic         ack;
      logic [31:0]  rdata;
      logic         vec;
      logic [14:0]  push_addr;
      logic         restore;
      logic         wake;
   } blk_state_t;

   blk_state_t s_r;
   blk_state_t s_nxt;

   logic ext_edge;
   logic req;
   logic wr_go;
   logic rd_go;
   logic take_irq;
   logic wake_src;
   logic [5:0] word;

   // ============================================================
   // pin edge detector
   ext_edge_detect u_edge
   (
      .clk_i                 (clk_i),
      .rst_i                 (rst_i),
      .ext_pin_i             (ext_pin_i),
      .ext_pin_edge_select_i (s_r.ext_pin_edge_select),
      .edge_o                (ext_edge)
   );

   // ============================================================
   // request and wake terms
   assign req   = read_i | write_i;
   assign wr_go = write_i & s_r.ack & byteenable_i[0];
   assign rd_go = read_i & s_r.ack;
   assign word  = address_i[7:2];

   assign take_irq = s_r.global_irq_enable                                // R07
                   & ((s_r.ext_pin_irq_flag & s_r.ext_pin_irq_enable)     // R04
                   | (s_r.peripheral_irq_master_enable
                   & (|(cell_flag_i & s_r.peripheral_irq_enable_three))));

   // the pin peripheral needs no system clock; cells say so themselves
   assign wake_src = (s_r.ext_pin_irq_flag & s_r.arm_inte)               // R13
                   | (s_r.arm_peripheral_irq_master_enable                                        // R01
                   & (|(cell_flag_i & s_r.arm_cell & cell_clockless_i)));

   // ============================================================
   // next state
   always_comb
   begin
      s_nxt         = s_r;
      s_nxt.vec     = 1'b0;
      s_nxt.restore = 1'b0;
      s_nxt.wake    = 1'b0;

      // one wait state: data is fetched on the first cycle
      s_nxt.ack   = req & ~s_r.ack;
      if (req && !s_r.ack)
      begin
         s_nxt.rdata = 32'h0000_0000;
         unique case (address_i)
            `OFS_IRQ_CONTROL:
            begin
               s_nxt.rdata[`CTL_GLOBAL_EN] = s_r.global_irq_enable;
               s_nxt.rdata[`CTL_PERIPH_EN] = s_r.peripheral_irq_master_enable;
               s_nxt.rdata[`CTL_INTE]     = s_r.ext_pin_irq_enable;
               s_nxt.rdata[`CTL_EDGE_SEL] = s_r.ext_pin_edge_select;
               s_nxt.rdata[`CTL_PIN_FLAG] = s_r.ext_pin_irq_flag;
            end
            `OFS_PERIPH_EN3:
               s_nxt.rdata[1:0] = s_r.peripheral_irq_enable_three; // R12
            `OFS_IRQ_STATUS:
               s_nxt.rdata[2:0] = s_r.sts;
            `OFS_IRQ_MASK:
               s_nxt.rdata[2:0] = s_r.msk;
            default:
            begin
               if (address_i >= `OFS_SHADOW_BASE
                   && address_i <= `OFS_SHADOW_LAST)
               begin
                  s_nxt.rdata[7:0] = s_r.shadow[word[2:0]]; // R11
               end
            end
         endcase
      end

      // register writes take effect on the edge after the one that ends waitrequest
      if (wr_go)
      begin
         unique case (address_i)
            `OFS_IRQ_CONTROL:
            begin
               s_nxt.global_irq_enable   = writedata_i[`CTL_GLOBAL_EN];
               s_nxt.peripheral_irq_master_enable
                  = writedata_i[`CTL_PERIPH_EN];
               s_nxt.ext_pin_irq_enable  = writedata_i[`CTL_INTE];
               s_nxt.ext_pin_edge_select = writedata_i[`CTL_EDGE_SEL];
               s_nxt.ext_pin_irq_flag    = writedata_i[`CTL_PIN_FLAG]; // R14
            end
            `OFS_PERIPH_EN3:
               s_nxt.peripheral_irq_enable_three = writedata_i[1:0]; // R12
            `OFS_IRQ_MASK:
               s_nxt.msk = writedata_i[2:0];
            default:
            begin
               if (address_i >= `OFS_SHADOW_BASE
                   && address_i <= `OFS_SHADOW_LAST)
               begin
                  s_nxt.shadow[word[2:0]] = writedata_i[7:0]; // R11
               end
            end
         endcase
      end

      // a status read clears only the bits it returned
      if (rd_go && address_i == `OFS_IRQ_STATUS)
      begin
         s_nxt.sts = s_r.sts & ~s_r.rdata[2:0];
      end

      // a pin edge wins over a software clear in the same cycle
      if (ext_edge)
      begin
         s_nxt.ext_pin_irq_flag = 1'b1; // R06
         s_nxt.sts[`STS_EXT_EDGE] = 1'b1;
      end

      unique case (s_r.state)
         ST_RUN:
         begin
            if (take_irq && instr_done_i)
            begin
               s_nxt.state = ST_ISR;
               s_nxt.vec   = 1'b1; // R07
            end
            else if (sleep_enter_i)
            begin
               // snapshot of enables as they stand when sleep begins
               s_nxt.state    = ST_SLEEP;
               s_nxt.arm_inte = s_r.ext_pin_irq_enable; // R01
               s_nxt.arm_peripheral_irq_master_enable = s_r.peripheral_irq_master_enable;
               s_nxt.arm_cell = s_r.peripheral_irq_enable_three;
            end
         end
         ST_SLEEP:
         begin
            if (wake_src)
            begin
               s_nxt.wake  = 1'b1;
               s_nxt.sts[`STS_WAKE] = 1'b1;
               s_nxt.state = s_r.global_irq_enable ? ST_WAKE_STEP
                                                   : ST_RUN; // R02
            end
         end
         ST_WAKE_STEP:
         begin
            if (instr_done_i)
            begin
               s_nxt.state = ST_ISR;
               s_nxt.vec   = 1'b1; // R03
            end
         end
         ST_ISR:
         begin
            if (return_i)
            begin
               s_nxt.state   = ST_RUN;
               s_nxt.restore = 1'b1; // R10
               s_nxt.global_irq_enable = 1'b1;
            end
         end
      endcase

      // interrupt entry: return address, shadows, global enable off
      if (s_nxt.vec)
      begin
         s_nxt.push_addr = pc_next_i; // R08
         s_nxt.global_irq_enable = 1'b0;
         s_nxt.sts[`STS_ENTRY] = 1'b1;
         for (int i = 0; i < `SHD_COUNT; i++)
         begin
            s_nxt.shadow[i] = core_regs_i[i*8 +: 8]; // R09
         end
         s_nxt.shadow[`SHD_STATUS] = core_regs_i[15:8]
                                   & `STATUS_KEEP_MASK; // R09
      end
   end

   // ============================================================
   // state register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_r       <= '0;
         s_r.state <= ST_RUN;
         s_r.peripheral_irq_enable_three <= `RST_PERIPH_EN3;
         s_r.sts   <= `RST_STATUS;
         s_r.msk   <= `RST_MASK;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // ============================================================
   // outputs
   assign waitrequest_o  = req & ~s_r.ack;
   assign readdata_o     = s_r.rdata;
   assign irq_o          = |(s_r.sts & s_r.msk);
   assign vector_o       = s_r.vec;
   assign push_pc_o      = s_r.vec;
   assign push_addr_o    = s_r.push_addr;
   assign restore_o      = s_r.restore;
   assign restore_regs_o = s_r.shadow; // R10
   assign wake_o         = s_r.wake;
   assign asleep_o       = (s_r.state == ST_SLEEP);

   // ============================================================
   // checks
   a_flag_on_edge: assert property (@(posedge clk_i) disable iff (rst_i)
      ext_edge |=> s_r.ext_pin_irq_flag)
      else $error("pin edge did not set the flag"); // R06

   a_vector_enables: assert property (@(posedge clk_i) disable iff (rst_i)
      (vector_o && $past(s_r.state) == ST_RUN) |->
         $past(s_r.global_irq_enable) && $past(instr_done_i))
      else $error("vector taken without global enable"); // R07

   a_pin_gated: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_r.state == ST_RUN && !s_r.ext_pin_irq_enable
       && !s_r.peripheral_irq_master_enable) |=> !vector_o)
      else $error("vector with every source disabled"); // R04

   a_push_addr: assert property (@(posedge clk_i) disable iff (rst_i)
      vector_o |-> push_pc_o && push_addr_o == $past(pc_next_i))
      else $error("return address not pushed on entry"); // R08

   a_shadow_save: assert property (@(posedge clk_i) disable iff (rst_i)
      vector_o |-> s_r.shadow[`SHD_W] == $past(core_regs_i[7:0])
        && s_r.shadow[`SHD_STATUS]
           == ($past(core_regs_i[15:8]) & `STATUS_KEEP_MASK))
      else $error("core registers not copied on entry"); // R09

   a_return_restore: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_r.state == ST_ISR && return_i) |=>
         restore_o && s_r.global_irq_enable && s_r.state == ST_RUN)
      else $error("return did not restore"); // R10

   a_wake_no_gie: assert property (@(posedge clk_i) disable iff (rst_i)
      (wake_o && !$past(s_r.global_irq_enable)) |->
         s_r.state == ST_RUN ##1 !vector_o)
      else $error("wake vectored with global enable off"); // R02

   a_step_first: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_r.state == ST_WAKE_STEP && !instr_done_i) |=> !vector_o)
      else $error("vector before the step after sleep"); // R03

   a_unarmed_sleep: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_r.state == ST_SLEEP && !s_r.arm_inte && !(s_r.arm_peripheral_irq_master_enable
       && |(cell_flag_i & s_r.arm_cell & cell_clockless_i))) |=> !wake_o)
      else $error("woke from a source not armed"); // R01

   a_enable3_upper: assert property (@(posedge clk_i) disable iff (rst_i)
      (read_i && s_r.ack && address_i == `OFS_PERIPH_EN3)
         |-> readdata_o[31:2] == 30'h0000_0000)
      else $error("upper enable bits read nonzero"); // R12

   a_shadow_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_go && address_i == `OFS_SHADOW_BASE && !s_nxt.vec)
         |=> s_r.shadow[`SHD_W] == $past(writedata_i[7:0]))
      else $error("shadow write lost"); // R11

endmodule // interrupt_wake_and_context_save

`default_nettype wire

// File: logic/irq_defs.svh
/*
 holds the register offsets, field positions and reset values of the
 interrupt, wake and context save block.
 assumes byte addressing on a 32-bit avalon-mm slave port.
*/
`ifndef IRQ_DEFS_SVH
`define IRQ_DEFS_SVH

// ============================================================
// register byte offsets
`define OFS_IRQ_CONTROL    8'h00
`define OFS_PERIPH_EN3     8'h04
`define OFS_IRQ_STATUS     8'h08
`define OFS_IRQ_MASK       8'h0c
`define OFS_SHADOW_BASE    8'h20
`define OFS_SHADOW_LAST    8'h3c

// ============================================================
// irq_control_reg fields
`define CTL_GLOBAL_EN      0
`define CTL_PERIPH_EN      1
`define CTL_INTE           2
`define CTL_EDGE_SEL       3
`define CTL_PIN_FLAG       4

// ============================================================
// peripheral_irq_enable_three fields
`define PERIPH_EN3_CELL1   0
`define PERIPH_EN3_CELL2   1

// ============================================================
// irq status and mask fields
`define STS_EXT_EDGE       0
`define STS_ENTRY          1
`define STS_WAKE           2

// ============================================================
// shadow slots, in order of the core register bundle
`define SHD_W              0
`define SHD_STATUS         1
`define SHD_BANK           2
`define SHD_PC_HIGH        7
`define SHD_COUNT          8

// status bits kept out of the shadow copy: timeout and power-down
`define STATUS_KEEP_MASK   8'he7

// ============================================================
// reset values
`define RST_CONTROL        5'h00
`define RST_PERIPH_EN3     2'h0
`define RST_STATUS         3'h0
`define RST_MASK           3'h0

`endif

// File: logic/irq_pkg.sv
/*
 holds the types of the interrupt, wake and context save block.
 assumes the constants of irq_defs.svh.
*/
`default_nettype none

package irq_pkg;

   // ============================================================
   // sequencer states
   typedef enum logic [1:0]
   {
      ST_RUN,
      ST_ISR,
      ST_SLEEP,
      ST_WAKE_STEP
   } irq_state_t;

   typedef logic [7:0][7:0] shadow_bank_t;

endpackage

`default_nettype wire

// File: tb/core_model.sv
/*
 model of the core instruction sequencer facing the interrupt block.
 assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module core_model
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // bench commands
   input  wire logic        slow_i,
   input  wire logic        sleep_req_i,
   input  wire logic        ret_req_i,
   // from interrupt block
   input  wire logic        restore_i,
   input  wire logic [63:0] restore_regs_i,
   input  wire logic        wake_i,
   // to interrupt block
   output logic             instr_done_o,
   output logic             sleep_enter_o,
   output logic             return_o,
   output logic      [14:0] pc_next_o,
   output logic      [63:0] core_regs_o
);
   logic [2:0] gap_r;
   logic       halt_r;

   // ============================================================
   // instruction stream, stopped between sleep and wake
   always @(posedge clk_i)
   begin
      instr_done_o  <= 1'b0;
      sleep_enter_o <= sleep_req_i;
      return_o      <= ret_req_i;
      if (rst_i)
      begin
         gap_r       <= 3'h0;
         halt_r      <= 1'b0;
         pc_next_o   <= 15'h0;
         core_regs_o <= 64'h0;
      end
      else
      begin
         if (sleep_req_i)
            halt_r <= 1'b1;
         else if (wake_i)
            halt_r <= 1'b0;
         // timeout and power-down bits stay live
         if (restore_i)
            core_regs_o <= {restore_regs_i[63:13], core_regs_o[12:11],
                            restore_regs_i[10:0]};
         else if (!halt_r && !sleep_req_i && gap_r == 3'h0)
         begin
            instr_done_o <= 1'b1;
            pc_next_o    <= pc_next_o + 15'h1;
            core_regs_o  <= {$urandom, $urandom};
            gap_r        <= slow_i ? 3'h4 : 3'h1;
         end
         else if (gap_r != 3'h0)
            gap_r <= gap_r - 3'h1;
      end
   end
endmodule // core_model

`default_nettype wire

// File: tb/tb_top.sv
/*
 self-checking bench of the interrupt, wake and context save block.
 assumes the register map of irq_defs.svh and the core model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "irq_defs.svh"

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_top;
   logic        clk_i, rst_i, read_i, write_i, waitrequest_o, irq_o;
   logic [7:0]  address_i;
   logic [3:0]  byteenable_i;
   logic [31:0] writedata_i, readdata_o, q, v, ctl;
   logic        ext_pin_i, instr_done_i, sleep_enter_i, return_i;
   logic [1:0]  cell_flag_i, cell_clockless_i;
   logic [14:0] pc_next_i, push_addr_o, pv_pc;
   logic [63:0] core_regs_i, restore_regs_o, pv_regs, exp_shadow, exp_restore;
   logic        vector_o, push_pc_o, restore_o, wake_o, asleep_o;
   logic        slow, sleep_req, ret_req, woke, arm_step;
   logic [3:0]  since_wake;
   int          vec_cnt, wake_cnt, rst_cnt, cyc, fail_count, check_count;

   interrupt_wake_and_context_save uut (.clk_i(clk_i), .rst_i(rst_i),
      .address_i(address_i), .read_i(read_i), .write_i(write_i),
      .byteenable_i(byteenable_i), .writedata_i(writedata_i),
      .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .irq_o(irq_o),
      .ext_pin_i(ext_pin_i), .cell_flag_i(cell_flag_i),
      .cell_clockless_i(cell_clockless_i), .instr_done_i(instr_done_i),
      .sleep_enter_i(sleep_enter_i), .return_i(return_i),
      .pc_next_i(pc_next_i), .core_regs_i(core_regs_i),
      .vector_o(vector_o), .push_pc_o(push_pc_o), .push_addr_o(push_addr_o),
      .restore_o(restore_o), .restore_regs_o(restore_regs_o),
      .wake_o(wake_o), .asleep_o(asleep_o));

   core_model core (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
      .sleep_req_i(sleep_req), .ret_req_i(ret_req), .restore_i(restore_o),
      .restore_regs_i(restore_regs_o), .wake_i(wake_o),
      .instr_done_o(instr_done_i), .sleep_enter_o(sleep_enter_i),
      .return_o(return_i), .pc_next_o(pc_next_i), .core_regs_o(core_regs_i));

   always #2.5 clk_i = ~clk_i;

   // ============================================================
   // tasks
   task give_verdict;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   function automatic logic [63:0] shadow_of(input logic [63:0] r);
      shadow_of       = r;
      shadow_of[15:8] = r[15:8] & `STATUS_KEEP_MASK;
   endfunction

   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk_i);
      address_i   <= a;
      writedata_i <= d;
      read_i      <= ~wr;
      write_i     <= wr;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (waitrequest_o !== 1'b0 && n < 100);
      if (n >= 100)
         fail_count++;
      r = readdata_o;
      read_i  <= 1'b0;
      write_i <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, q);
   endtask

   task chk_rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, q);
      `CHK(q, e)
   endtask

   task pin(input logic lvl);
      @(posedge clk_i);
      ext_pin_i <= lvl;
      repeat (3 + $urandom % 4) @(posedge clk_i);
   endtask

   task cmd(input logic is_sleep);
      @(posedge clk_i);
      if (is_sleep)
         sleep_req <= 1'b1;
      else
         ret_req <= 1'b1;
      @(posedge clk_i);
      sleep_req <= 1'b0;
      ret_req   <= 1'b0;
   endtask

   task automatic wait_for(ref int cnt, input int want);
      int n;
      n = 0;
      while (cnt < want && n < 200)
      begin
         @(posedge clk_i);
         n++;
      end
      `CHK(cnt, want)
   endtask

   // ============================================================
   // monitor of core commands
   always @(posedge clk_i)
   begin
      cyc++;
      if (vector_o === 1'b1)
      begin
         vec_cnt++;
         `CHK(push_pc_o, 1'b1)
         `CHK(push_addr_o, pv_pc)
         exp_shadow = shadow_of(pv_regs);
         if (woke)
            `CHK(since_wake, 4'h1)
         woke = 1'b0;
      end
      if (restore_o === 1'b1)
      begin
         rst_cnt++;
         `CHK(restore_regs_o, exp_restore)
      end
      if (instr_done_i === 1'b1)
         since_wake++;
      if (wake_o === 1'b1)
      begin
         wake_cnt++;
         woke = arm_step;
         since_wake = 4'h0;
      end
      pv_pc = pc_next_i;
      pv_regs = core_regs_i;
      if (cyc == 20000)
      begin
         fail_count++;
         give_verdict;
      end
   end

   // ============================================================
   // main sequence
   initial
   begin
      clk_i = 0; rst_i = 1; read_i = 0; write_i = 0; address_i = 8'h0;
      byteenable_i = 4'hf; writedata_i = 32'h0; ext_pin_i = 0;
      cell_flag_i = 2'h0; cell_clockless_i = 2'h0; slow = 0; sleep_req = 0;
      ret_req = 0; woke = 0; arm_step = 0; since_wake = 4'h0;
      void'($urandom(32'hf553));
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      chk_rd(`OFS_IRQ_CONTROL, 32'h0);
      chk_rd(`OFS_PERIPH_EN3, 32'h0);
      chk_rd(`OFS_IRQ_STATUS, 32'h0);
      v = $urandom;
      wr(`OFS_PERIPH_EN3, v);
      chk_rd(`OFS_PERIPH_EN3, {30'h0, v[1:0]});
      wr(8'h10, 32'hff);
      chk_rd(8'h10, 32'h0);
      $display("test registers done");
      for (int s = 0; s < 2; s++)
      begin
         ctl = {28'h0, s[0], 3'b100};
         wr(`OFS_IRQ_CONTROL, ctl);
         pin(~s[0]);
         wr(`OFS_IRQ_CONTROL, ctl);
         bus(1'b0, `OFS_IRQ_STATUS, 32'h0, q);
         pin(s[0]);
         chk_rd(`OFS_IRQ_CONTROL, ctl | 32'h10);
         `CHK(irq_o, 1'b0)
         chk_rd(`OFS_IRQ_STATUS, 32'h1);
         chk_rd(`OFS_IRQ_STATUS, 32'h0);
         wr(`OFS_IRQ_CONTROL, ctl);
         pin(~s[0]);
         chk_rd(`OFS_IRQ_CONTROL, ctl);
      end
      $display("test edges done");
      wr(`OFS_IRQ_MASK, 32'h2);
      wr(`OFS_IRQ_CONTROL, 32'h17);
      wait_for(vec_cnt, 1);
      @(posedge clk_i);
      `CHK(irq_o, 1'b1)
      chk_rd(`OFS_IRQ_CONTROL, 32'h16);
      chk_rd(`OFS_IRQ_STATUS, 32'h2);
      @(posedge clk_i);
      `CHK(irq_o, 1'b0)
      for (int i = 0; i < 8; i++)
         chk_rd(`OFS_SHADOW_BASE + 8'(4 * i), {24'h0, exp_shadow[8*i+:8]});
      v = $urandom;
      wr(`OFS_SHADOW_BASE, {24'h0, v[7:0]});
      exp_restore = {exp_shadow[63:8], v[7:0]};
      wr(`OFS_IRQ_CONTROL, 32'h06);
      cmd(1'b0);
      wait_for(rst_cnt, 1);
      chk_rd(`OFS_IRQ_CONTROL, 32'h07);
      wr(`OFS_IRQ_CONTROL, 32'h13);
      repeat (20) @(posedge clk_i);
      `CHK(vec_cnt, 1)
      $display("test entry done");
      wr(`OFS_IRQ_MASK, 32'h4);
      pin(1'b1);
      wr(`OFS_IRQ_CONTROL, 32'h04);
      bus(1'b0, `OFS_IRQ_STATUS, 32'h0, q);
      cmd(1'b1);
      repeat (3) @(posedge clk_i);
      `CHK(asleep_o, 1'b1)
      pin(1'b0);
      wait_for(wake_cnt, 1);
      repeat (20) @(posedge clk_i);
      `CHK(vec_cnt, 1)
      `CHK(irq_o, 1'b1)
      chk_rd(`OFS_IRQ_STATUS, 32'h5);
      wr(`OFS_IRQ_CONTROL, 32'h04);
      wr(`OFS_IRQ_CONTROL, 32'h05);
      pin(1'b1);
      arm_step = 1'b1;
      slow <= 1'b1;
      cmd(1'b1);
      pin(1'b0);
      wait_for(vec_cnt, 2);
      exp_restore = exp_shadow;
      wr(`OFS_IRQ_CONTROL, 32'h04);
      cmd(1'b0);
      wait_for(rst_cnt, 2);
      slow <= 1'b0;
      $display("test wake done");
      wr(`OFS_IRQ_CONTROL, 32'h02);
      wr(`OFS_PERIPH_EN3, 32'h3);
      cmd(1'b1);
      wr(`OFS_IRQ_CONTROL, 32'h06);
      pin(1'b1);
      pin(1'b0);
      `CHK(wake_cnt, 2)
      cell_flag_i <= 2'h1;
      repeat (10) @(posedge clk_i);
      `CHK(asleep_o, 1'b1)
      cell_clockless_i <= 2'h1;
      wait_for(wake_cnt, 3);
      cell_flag_i <= 2'h0;
      $display("test sleep sources done");
      give_verdict;
   end
endmodule // tb_top

`default_nettype wire
